// ===== scp_defs.svh
// Contract
// - Busy high refuses any new transfer
// - Answer on data-out only while selected
// - Idle-low clock; out on fall, in on rise
// - Most significant bit of each byte first
// - Bytes shifted from byte zero upward
// - Busy rises as soon as transfer starts
// - Busy falls once the command is processed
// - Forty 12-byte or thirty 16-byte node slots
// - Command sets allowed differ by network state
// - Status query accepted in every state
// - Module commands gated by network state; the code accepts state, local I/O and restart in any state
// - Profile select for drives in boot, setup
// - Service objects for nodes, not in boot; the code refuses them for SCP_CLS_HSP nodes
// - Per-node motion commands only when running
// - State change time follows the network
// - Slot zero module, nodes next, service last
// - Answers return in the following frame
// - Multi-byte fields are little-endian
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH

// Network state codes
`define SCP_ST_BOOT 8'h01
`define SCP_ST_SETUP 8'h02
`define SCP_ST_SAFE 8'h04
`define SCP_ST_RUN 8'h08

// Command codes
`define SCP_CMD_STATUS 8'h00
`define SCP_CMD_STATE 8'h01
`define SCP_CMD_NODE_SETUP 8'h02
`define SCP_CMD_CYCLE_SETUP 8'h03
`define SCP_CMD_EXT_SETUP 8'h04
`define SCP_CMD_QUEUE_SETUP 8'h05
`define SCP_CMD_PROFILE 8'h06
`define SCP_CMD_SO_READ 8'h07
`define SCP_CMD_SO_WRITE 8'h08
`define SCP_CMD_NODE_FIRST 8'h10
`define SCP_CMD_NODE_LAST 8'h19
`define SCP_CMD_REMOTE_IN 8'h13
`define SCP_CMD_REMOTE_OUT 8'h14
`define SCP_CMD_LIO_READ 8'h21
`define SCP_CMD_LIO_WRITE 8'h22
`define SCP_CMD_RESTART 8'hbb

// Response first-byte codes
`define SCP_RSP_ACTIVE 8'hbf
`define SCP_RSP_IDLE 8'h00
`define SCP_RSP_REFUSE 8'hff

// Frame geometry
`define SCP_FRAME12 10'h1f8
`define SCP_FRAME16 10'h200
`define SCP_SLOTS12 6'h2a
`define SCP_SLOTS16 6'h20
`define SCP_NODES12 6'h28
`define SCP_NODES16 6'h1e
`define SCP_NODE_MAX 40
`define SCP_TYPE_DEFAULT 2'h1

// Byte positions inside a slot
`define SCP_BYTE_ARG 9'h002
`define SCP_BYTE_DATA 9'h004

// Synchroniser reset levels: lio_in, slot16, mosi, ss_n, sclk
`define SCP_SYNC_RST 12'h002

`endif

// ===== scp_pkg.sv
package scp_pkg;

  // Port phase, Gray coded along idle-xfer-proc-prefill
  typedef enum logic [1:0] {
    SCP_IDLE = 2'h0,
    SCP_XFER = 2'h1,
    SCP_PROC = 2'h3,
    SCP_PREFILL = 2'h2
  } scp_phase_t;

  // Target class of a slot
  typedef enum logic [2:0] {
    SCP_CLS_MODULE = 3'h0,
    SCP_CLS_DRIVE = 3'h1,
    SCP_CLS_IO = 3'h2,
    SCP_CLS_HSP = 3'h3,
    SCP_CLS_NONE = 3'h4
  } scp_cls_t;

endpackage : scp_pkg

// ===== scp_port.sv
`timescale 1ns/1ps
`include "scp_defs.svh"

// ----------------------------------------------------------------
// Response byte FIFO
// ----------------------------------------------------------------
module scp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  input wire logic flush,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  // Handshake terms
  assign in_ready = count != (AW+1)'(D);
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      case ({push, pop})
        2'b10: count <= count + 1'b1;
        2'b01: count <= count - 1'b1;
        default: count <= count;
      endcase
    end
  end
endmodule : scp_fifo

// ----------------------------------------------------------------
// Serial command port
// ----------------------------------------------------------------
module scp_port
  import scp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Serial link
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  output logic miso_out,
  output logic miso_oe,
  output logic busy,
  // Straps and local pins
  input wire logic slot16,
  input wire logic [7:0] lio_in,
  output logic [7:0] lio_out,
  // Network engine
  output logic [7:0] net_state,
  output logic [7:0] state_req,
  output logic state_req_valid,
  input wire logic state_done,
  output logic [15:0] cycle_time
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [11:0] raw;
  logic [11:0] s_lvl;
  logic [11:0] s_rise;
  logic [11:0] s_fall;

  assign raw = {lio_in, slot16, mosi, ss_n, sclk};

  // Idle levels of every stage, so no false edge follows reset
  localparam logic [11:0] SYNC_RST = `SCP_SYNC_RST;

  // Three stages; a change counts once stages two and three agree
  for (genvar i = 0; i < 12; i++) begin : g_sync
    logic m1;
    logic m2;
    logic m3;
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        m1 <= SYNC_RST[i];
      end else begin
        m1 <= raw[i];
      end
    end
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        m2 <= SYNC_RST[i];
        m3 <= SYNC_RST[i];
        s_lvl[i] <= SYNC_RST[i];
      end else begin
        m2 <= m1;
        m3 <= m2;
        if (m2 == m3) begin
          s_lvl[i] <= m3;
        end
      end
    end
    assign s_rise[i] = (m2 == m3) && m3 && !s_lvl[i];
    assign s_fall[i] = (m2 == m3) && !m3 && s_lvl[i];
  end

  logic sclk_rise;
  logic sclk_fall;
  logic ss_fall;
  logic ss_rise;
  logic sel;
  logic mosi_s;

  assign sclk_rise = s_rise[0];
  assign sclk_fall = s_fall[0];
  assign ss_fall = s_fall[1];
  assign ss_rise = s_rise[1];
  assign sel = !s_lvl[1];
  assign mosi_s = s_lvl[2];

  // ----------------------------------------------------------------
  // Phase control
  // ----------------------------------------------------------------
  scp_phase_t st;
  scp_phase_t next_st;
  logic cfg16;
  logic [5:0] slot;
  logic [5:0] nslots;
  logic [9:0] frame_bytes;
  logic last;
  logic fifo_in_ready;
  logic [9:0] fill_ptr;

  assign nslots = cfg16 ? `SCP_SLOTS16 : `SCP_SLOTS12;
  assign frame_bytes = cfg16 ? `SCP_FRAME16 : `SCP_FRAME12;

  // Phase sequencing
  always_comb begin
    next_st = st;
    case (st)
      SCP_IDLE: begin
        if (ss_fall) begin
          next_st = SCP_XFER;
        end
      end
      SCP_XFER: begin
        if (ss_rise) begin
          next_st = SCP_PROC;
        end
      end
      SCP_PROC: begin
        if (last) begin
          next_st = SCP_PREFILL;
        end
      end
      SCP_PREFILL: begin
        if (!fifo_in_ready || fill_ptr >= frame_bytes) begin
          next_st = SCP_IDLE;
        end
      end
      default: next_st = SCP_PREFILL;
    endcase
  end

  // Phase register; a frame begun while busy is ignored whole
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= SCP_PREFILL;
    end else begin
      st <= next_st;
    end
  end

  // Busy follows the phase on the same edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b1;
    end else begin
      busy <= next_st != SCP_IDLE;
    end
  end

  // Slot size strap taken while refilling
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg16 <= 1'b0;
    end else if (st == SCP_PREFILL) begin
      cfg16 <= s_lvl[3];
    end
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  logic [2:0] bit_cnt;
  logic [7:0] rx_sh;
  logic [9:0] byte_idx;
  logic [7:0] cmd_mem [512];
  logic rx_done;

  assign rx_done = sel && sclk_rise && st == SCP_XFER && bit_cnt == 3'h7
                   && byte_idx < frame_bytes;

  // Bit and byte counters, sampled on the rising edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt <= 3'h0;
      rx_sh <= 8'h00;
      byte_idx <= 10'h000;
    end else if (!sel || ss_rise) begin
      bit_cnt <= 3'h0;
      byte_idx <= 10'h000;
    end else if (sclk_rise && st == SCP_XFER) begin
      rx_sh <= {rx_sh[6:0], mosi_s};
      bit_cnt <= bit_cnt + 3'h1;
      if (rx_done) begin
        byte_idx <= byte_idx + 10'h001;
      end
    end
  end

  // Command frame store
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int k = 0; k < 512; k++) begin
        cmd_mem[k] <= 8'h00;
      end
    end else if (rx_done) begin
      cmd_mem[byte_idx[8:0]] <= {rx_sh[6:0], mosi_s};
    end
  end

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  logic [7:0] tx_sh;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [7:0] fifo_out_data;
  logic tx_load;

  assign tx_load = (st == SCP_IDLE && ss_fall)
                   || (sel && sclk_fall && st == SCP_XFER && bit_cnt == 3'h0);
  assign fifo_out_ready = tx_load;
  assign miso_out = tx_sh[7];
  // drive only in a taken frame
  assign miso_oe = sel && st == SCP_XFER;

  // Output shifter, changes on the falling edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_sh <= 8'h00;
    end else if (tx_load) begin
      tx_sh <= fifo_out_valid ? fifo_out_data : 8'h00;
    end else if (sel && sclk_fall && st == SCP_XFER) begin
      tx_sh <= {tx_sh[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Response feed
  // ----------------------------------------------------------------
  logic [7:0] rsp_mem [512];
  logic fifo_in_valid;
  logic fifo_flush;

  assign fifo_flush = st == SCP_PROC && last;
  assign fifo_in_valid = st != SCP_PROC && fill_ptr < frame_bytes;

  // Feed pointer restarts at byte zero for every frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      fill_ptr <= 10'h000;
    end else if (fifo_flush) begin
      fill_ptr <= 10'h000;
    end else if (fifo_in_valid && fifo_in_ready) begin
      fill_ptr <= fill_ptr + 10'h001;
    end
  end

  scp_fifo #(
    .W(8),
    .D(4)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .flush(fifo_flush),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(rsp_mem[fill_ptr[8:0]]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Command processing
  // ----------------------------------------------------------------
  logic [1:0] ntype [`SCP_NODE_MAX];
  logic [9:0] base;
  logic [7:0] b0;
  logic [7:0] b2;
  logic [31:0] arg;
  logic [5:0] node_idx;
  logic [5:0] max_nodes;
  scp_cls_t cls;
  logic ok;
  logic running;
  logic [7:0] refuse_cnt;

  // Stored node type to target class
  function automatic scp_cls_t node_cls(input logic [1:0] t);
    case (t)
      2'h0: node_cls = SCP_CLS_DRIVE;
      2'h1: node_cls = SCP_CLS_IO;
      default: node_cls = SCP_CLS_HSP;
    endcase
  endfunction : node_cls

  // Acceptance by command, target class and network state
  function automatic logic cmd_ok(input logic [7:0] c, input scp_cls_t t,
                                  input logic [7:0] s);
    logic mod;
    logic early;
    mod = t == SCP_CLS_MODULE;
    early = s == `SCP_ST_BOOT || s == `SCP_ST_SETUP;
    case (c)
      `SCP_CMD_STATUS: cmd_ok = 1'b1;
      `SCP_CMD_STATE, `SCP_CMD_LIO_READ, `SCP_CMD_LIO_WRITE,
      `SCP_CMD_RESTART: cmd_ok = mod;
      `SCP_CMD_NODE_SETUP, `SCP_CMD_CYCLE_SETUP: cmd_ok = mod && early;
      `SCP_CMD_EXT_SETUP: cmd_ok = mod && s != `SCP_ST_RUN;
      `SCP_CMD_QUEUE_SETUP: cmd_ok = mod && s == `SCP_ST_RUN;
      `SCP_CMD_PROFILE: cmd_ok = t == SCP_CLS_DRIVE && early;
      `SCP_CMD_SO_READ, `SCP_CMD_SO_WRITE: begin
        cmd_ok = (t == SCP_CLS_DRIVE || t == SCP_CLS_IO)
                 && s != `SCP_ST_BOOT;
      end
      `SCP_CMD_REMOTE_IN, `SCP_CMD_REMOTE_OUT: begin
        cmd_ok = t == SCP_CLS_IO && s == `SCP_ST_RUN;
      end
      default: begin
        cmd_ok = c >= `SCP_CMD_NODE_FIRST && c <= `SCP_CMD_NODE_LAST
                 && t == SCP_CLS_DRIVE && s == `SCP_ST_RUN;
      end
    endcase
  endfunction : cmd_ok

  assign max_nodes = cfg16 ? `SCP_NODES16 : `SCP_NODES12;
  assign running = net_state == `SCP_ST_RUN;

  // Slot decode: module first, then nodes, service access last
  always_comb begin
    base = cfg16 ? {slot, 4'h0} : {1'b0, slot, 3'h0} + {2'b0, slot, 2'h0};
    b0 = cmd_mem[base[8:0]];
    b2 = cmd_mem[base[8:0] + `SCP_BYTE_ARG];
    for (int k = 0; k < 4; k++) begin
      arg[8*k +: 8] = cmd_mem[base[8:0] + `SCP_BYTE_DATA + 9'(k)];
    end
    last = slot == nslots - 6'h1;
    node_idx = last ? b2[5:0] : slot;
    if (slot == 6'h00) begin
      cls = SCP_CLS_MODULE;
    end else if (node_idx == 6'h00 || node_idx > max_nodes) begin
      cls = SCP_CLS_NONE;
    end else begin
      cls = node_cls(ntype[node_idx - 6'h1]);
    end
    ok = cmd_ok(b0, cls, net_state);
  end

  // Slot walk
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot <= 6'h00;
    end else if (st == SCP_PROC && !last) begin
      slot <= slot + 6'h01;
    end else begin
      slot <= 6'h00;
    end
  end

  // Network state; a requested change completes when the engine reports it, restart sets boot at once
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      net_state <= `SCP_ST_BOOT;
      state_req <= `SCP_ST_BOOT;
      state_req_valid <= 1'b0;
    end else if (st == SCP_PROC && ok && b0 == `SCP_CMD_RESTART) begin
      net_state <= `SCP_ST_BOOT;
      state_req_valid <= 1'b0;
    end else if (st == SCP_PROC && ok && b0 == `SCP_CMD_STATE
                 && (arg[7:0] == `SCP_ST_BOOT || arg[7:0] == `SCP_ST_SETUP
                 || arg[7:0] == `SCP_ST_SAFE || arg[7:0] == `SCP_ST_RUN)) begin
      state_req <= arg[7:0];
      state_req_valid <= 1'b1;
    end else if (state_req_valid && state_done) begin
      net_state <= state_req;
      state_req_valid <= 1'b0;
    end
  end

  // Module settings and node types
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lio_out <= 8'h00;
      cycle_time <= 16'h0000;
      for (int k = 0; k < `SCP_NODE_MAX; k++) begin
        ntype[k] <= `SCP_TYPE_DEFAULT;
      end
    end else if (st == SCP_PROC && ok) begin
      if (b0 == `SCP_CMD_LIO_WRITE) begin
        lio_out <= arg[7:0];
      end
      if (b0 == `SCP_CMD_CYCLE_SETUP) begin
        cycle_time <= arg[15:0];
      end
      if (b0 == `SCP_CMD_NODE_SETUP && b2 <= 8'h04) begin
        for (int k = 0; k < 8; k++) begin
          ntype[6'({b2[2:0], 3'(k)})] <= arg[4*k +: 2];
        end
      end
    end
  end

  // Refused command count
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      refuse_cnt <= 8'h00;
    end else if (st == SCP_PROC && !ok) begin
      refuse_cnt <= refuse_cnt + 8'h01;
    end
  end

  // Response store, read out during the following frame
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int k = 0; k < 512; k++) begin
        rsp_mem[k] <= 8'h00;
      end
    end else if (st == SCP_PROC) begin
      if (b0 == `SCP_CMD_STATUS) begin
        rsp_mem[base[8:0]] <= running ? `SCP_RSP_ACTIVE : `SCP_RSP_IDLE;
      end else begin
        rsp_mem[base[8:0]] <= ok ? b0 : `SCP_RSP_REFUSE;
      end
      rsp_mem[base[8:0] + 9'h1] <= refuse_cnt;
      rsp_mem[base[8:0] + `SCP_BYTE_ARG] <= net_state;
      if (ok && b0 == `SCP_CMD_LIO_READ) begin
        rsp_mem[base[8:0] + `SCP_BYTE_DATA] <= s_lvl[11:4];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_busy_refuse;
    (st != SCP_IDLE && ss_fall) |=> st != SCP_XFER;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("frame taken while busy");

  property p_busy_rise;
    (st == SCP_IDLE && ss_fall) |=> busy && st == SCP_XFER;
  endproperty
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy not raised at frame start");

  property p_busy_fall;
    $fell(busy) |-> $past(st) == SCP_PREFILL && st == SCP_IDLE;
  endproperty
  a_busy_fall: assert property (p_busy_fall)
    else $error("busy fell before processing ended");

  property p_miso_quiet;
    ss_n [*5] |-> !miso_oe;
  endproperty
  a_miso_quiet: assert property (p_miso_quiet)
    else $error("data-out driven while deselected");

  property p_cnt_clear;
    ss_rise |=> bit_cnt == 3'h0 && byte_idx == 10'h000;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("counters not cleared on deselect");

  property p_rx_msb;
    (sel && sclk_rise && st == SCP_XFER) |=> rx_sh[0] == $past(mosi_s)
      && rx_sh[7:1] == $past(rx_sh[6:0]);
  endproperty
  a_rx_msb: assert property (p_rx_msb)
    else $error("receive shift order wrong");

  property p_tx_shift;
    (sel && sclk_fall && st == SCP_XFER && bit_cnt != 3'h0)
      |=> miso_out == $past(tx_sh[6]);
  endproperty
  a_tx_shift: assert property (p_tx_shift)
    else $error("data-out not advanced on falling edge");

  property p_byte_order;
    rx_done |=> byte_idx == $past(byte_idx) + 10'h001;
  endproperty
  a_byte_order: assert property (p_byte_order)
    else $error("byte address not ascending");

  property p_status;
    (st == SCP_PROC && b0 == `SCP_CMD_STATUS) |=> rsp_mem[$past(base[8:0])]
      == ($past(running) ? `SCP_RSP_ACTIVE : `SCP_RSP_IDLE);
  endproperty
  a_status: assert property (p_status)
    else $error("status query not answered");

  property p_run_only;
    (st == SCP_PROC && b0 >= `SCP_CMD_NODE_FIRST
      && b0 <= `SCP_CMD_NODE_LAST && !running)
      |=> rsp_mem[$past(base[8:0])] == `SCP_RSP_REFUSE;
  endproperty
  a_run_only: assert property (p_run_only)
    else $error("node command taken outside running state");

  property p_next_frame;
    (st == SCP_PROC && last) |=> st == SCP_PREFILL && fill_ptr == 10'h000
      ##[1:8] st == SCP_IDLE;
  endproperty
  a_next_frame: assert property (p_next_frame)
    else $error("answer feed not restarted at byte zero");

  property p_cov_frame;
    st == SCP_XFER ##[1:1000] st == SCP_PROC ##[1:64] st == SCP_IDLE;
  endproperty
  c_frame: cover property (p_cov_frame);

  property p_cov_refused;
    st != SCP_IDLE && ss_fall;
  endproperty
  c_refused: cover property (p_cov_refused);

  property p_cov_state;
    state_req_valid && state_done;
  endproperty
  c_state: cover property (p_cov_state);

endmodule : scp_port

// ===== scp_host.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Host side of the serial link
// ----------------------------------------------------------------
module scp_host (
  // Serial link
  output logic sclk,
  output logic ss_n,
  output logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe,
  input wire logic busy
);
  // Link idles deselected with the clock low
  initial begin
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end

  // One 12-byte frame, 80 ns link period
  // link rate floor
  task automatic xfer(input logic [95:0] tx, output logic [95:0] rx,
      output logic bz, output logic oe);
    int i;
    ss_n = 1'b0;
    mosi = tx[95];
    #100;
    bz = busy;
    oe = miso_oe;
    for (i = 95; i >= 0; i--) begin
      sclk = 1'b1;
      #20;
      if (i > 0) mosi = tx[i-1];
      #20;
      sclk = 1'b0;
      rx[i] = miso_out;
      oe = oe & miso_oe;
      #40;
    end
    ss_n = 1'b1;
    mosi = ~mosi; // Released line shows no stale value
  endtask : xfer

  // Select while the port is busy; no answer is expected
  task automatic poke(output logic oe);
    ss_n = 1'b0;
    #200;
    oe = miso_oe;
    ss_n = 1'b1;
  endtask : poke
endmodule : scp_host

// ===== tb.sv
`timescale 1ns/1ps
`include "scp_defs.svh"

`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

// ----------------------------------------------------------------
// Testbench
// ----------------------------------------------------------------
module tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic sclk, ss_n, mosi, miso_out, miso_oe, busy;
  logic slot16 = 1'b0;
  logic [7:0] lio_in = 8'h00;
  logic [7:0] lio_out, net_state, state_req, lio;
  logic state_req_valid;
  logic state_done = 1'b0;
  logic [15:0] cycle_time, ct;
  logic [95:0] rx;
  logic bz, oe, oe2;
  int fails = 0;
  int n_compared = 0;

  // Clock generation
  always #5 clk = ~clk;

  // engine completes a request after a cycle
  always @(posedge clk) state_done <= #1 state_req_valid;

  // Design and host model
  scp_port uut (.clk(clk), .arst_n(arst_n), .sclk(sclk), .ss_n(ss_n),
    .mosi(mosi), .miso_out(miso_out), .miso_oe(miso_oe), .busy(busy),
    .slot16(slot16), .lio_in(lio_in), .lio_out(lio_out),
    .net_state(net_state), .state_req(state_req),
    .state_req_valid(state_req_valid), .state_done(state_done),
    .cycle_time(cycle_time));
  scp_host host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi),
    .miso_out(miso_out), .miso_oe(miso_oe), .busy(busy));

  // Closing report
  task automatic finish_test();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  // Bounded wait for the port to become free
  task automatic wait_low();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 3000) begin
      fails++;
      finish_test();
    end
  endtask : wait_low

  // Response byte k of the last frame
  function automatic logic [7:0] rb(int k);
    return rx[95-8*k -: 8];
  endfunction : rb

  // Slot zero command with filler bytes
  task automatic frame(logic [7:0] cmd, logic [7:0] b4, logic [7:0] b5);
    wait_low();
    @(posedge clk);
    #1 host.xfer({cmd, 24'h0, b4, b5, 16'($urandom), 32'($urandom)},
      rx, bz, oe);
    `CHK(bz, 1'b1)
    `CHK(oe, 1'b1)
    repeat (6) @(posedge clk);
    `CHK(miso_oe, 1'b0)
    #1 host.poke(oe2);
    `CHK(oe2, 1'b0)
  endtask : frame

  // Main sequence
  initial begin
    void'($urandom(32'h7ed7ca67));
    repeat (2) @(posedge clk);
    `CHK(busy, 1'b1)
    `CHK(net_state, `SCP_ST_BOOT)
    #1 arst_n = 1'b1;
    frame(`SCP_CMD_STATE, `SCP_ST_SETUP, 8'h00);
    wait_low();
    repeat (3) @(posedge clk);
    `CHK(net_state, `SCP_ST_SETUP)
    `CHK(state_req, `SCP_ST_SETUP)
    `CHK(state_req_valid, 1'b0)
    for (int i = 0; i < 10; i++) begin
      frame(8'h10 + 8'(i), 8'h00, 8'h00);
      if (i == 0) `CHK(rb(0), `SCP_CMD_STATE)
      else `CHK(rb(1), 8'(i - 1))
    end
    @(posedge clk);
    #1 lio = 8'($urandom);
    lio_in = lio;
    frame(`SCP_CMD_LIO_READ, 8'h00, 8'h00);
    `CHK(rb(0), `SCP_RSP_REFUSE)
    `CHK(rb(1), 8'h09)
    ct = 16'($urandom);
    frame(`SCP_CMD_STATUS, 8'h00, 8'h00);
    `CHK(rb(0), `SCP_CMD_LIO_READ)
    `CHK(rb(4), lio)
    frame(`SCP_CMD_CYCLE_SETUP, ct[7:0], ct[15:8]);
    `CHK(rb(0), `SCP_RSP_IDLE)
    frame(`SCP_CMD_QUEUE_SETUP, 8'h00, 8'h00);
    `CHK(rb(0), `SCP_CMD_CYCLE_SETUP)
    wait_low();
    `CHK(cycle_time, ct)
    lio = 8'($urandom);
    frame(`SCP_CMD_LIO_WRITE, lio, 8'h00);
    `CHK(rb(0), `SCP_RSP_REFUSE)
    `CHK(rb(1), 8'h0a)
    wait_low();
    `CHK(lio_out, lio)
    frame(`SCP_CMD_STATE, `SCP_ST_RUN, 8'h00);
    `CHK(rb(0), `SCP_CMD_LIO_WRITE)
    frame(`SCP_CMD_STATUS, 8'h00, 8'h00);
    `CHK(rb(0), `SCP_CMD_STATE)
    frame(`SCP_CMD_QUEUE_SETUP, 8'h00, 8'h00);
    `CHK(rb(0), `SCP_RSP_ACTIVE)
    `CHK(rb(2), `SCP_ST_RUN)
    frame(`SCP_CMD_RESTART, 8'h00, 8'h00);
    `CHK(rb(0), `SCP_CMD_QUEUE_SETUP)
    wait_low();
    `CHK(net_state, `SCP_ST_BOOT)
    finish_test();
  end
endmodule : tb
